// >>> bench/cosync_can_model.sv
// Far-side model: CAN controller traffic and bus occupancy seen by the scheduler
`timescale 1ns/10ps
module cosync_can_model (
	// Clock
	input  wire logic clk_i,
	// Scheduler requests and bench control
	input  wire logic sync_req_i,
	input  wire logic pdo_req_i,
	input  wire logic busy_cmd_i,
	// Bus state and event log
	output logic      bus_busy_o,
	output logic      tx_pending_o,
	output int        sync_cnt_o,
	output int        pdo_cnt_o,
	output int        sync_at_o,
	output int        pdo_at_o
);
	int cyc;

	initial begin
		cyc = 0;
		sync_cnt_o = 0;
		pdo_cnt_o = 0;
		sync_at_o = 0;
		pdo_at_o = 0;
		tx_pending_o = 1'b0;
	end

	// A foreign frame holds the bus for as long as the bench commands it
	assign bus_busy_o = busy_cmd_i;

	// Log request pulses; queued outputs stay pending until the next SYNC frees them
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (sync_req_i === 1'b1) begin
			sync_cnt_o <= sync_cnt_o + 1;
			sync_at_o <= cyc;
			tx_pending_o <= 1'b0;
		end
		if (pdo_req_i === 1'b1) begin
			pdo_cnt_o <= pdo_cnt_o + 1;
			pdo_at_o <= cyc;
			tx_pending_o <= 1'b1;
		end
	end
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the SYNC scheduler over APB and its event lines
`timescale 1ns/10ps
module testbench;
	import cosync_pkg::*;
	logic        clk = 1'b0;
	logic        rstn, psel, penable, pwrite, busy, busy_w, err_seen;
	logic        pready, pslverr, trig, sreq, preq, hold, crst, txp;
	logic [3:0]  evv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, edata;
	logic [10:0] hbid;
	int          err_count, n_tests, sc, pc, sa, pa, cyc, tev, c;

	cosync_sched #(.EMCY_DEPTH(4)) dut_u (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.TASK_START_I(evv[0]), .TASK_END_I(evv[1]), .HWLINK_I(evv[2]), .TASK_TRIG_O(trig),
		.BUS_BUSY_I(busy_w), .TX_PENDING_I(txp), .EMCY_VALID_I(evv[3]),
		.EMCY_DATA_I(edata), .SYNC_REQ_O(sreq), .PDO_REQ_O(preq), .TX_HOLD_O(hold),
		.COMM_RESET_O(crst), .HB_ID_O(hbid));
	cosync_can_model can_u (.clk_i(clk), .sync_req_i(sreq), .pdo_req_i(preq),
		.busy_cmd_i(busy), .bus_busy_o(busy_w), .tx_pending_o(txp), .sync_cnt_o(sc),
		.pdo_cnt_o(pc), .sync_at_o(sa), .pdo_at_o(pa));

	// 50 MHz clock and a cycle count matching the model's time stamps
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task finish_test;
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask

	// APB transfer; request held until PREADY is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			finish_test;
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask

	// One-cycle event pulse; tev is the edge at which the design sees it
	task pulse(input int i);
		@(posedge clk);
		evv[i] <= 1'b1;
		@(posedge clk);
		evv[i] <= 1'b0;
		tev = cyc;
	endtask

	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Fires one event and checks how many SYNCs follow within 20 cycles
	task ev_sync(input string nm, input int i, input int e);
		c = sc;
		pulse(i);
		idle(20);
		chk(nm, 32'(sc - c), 32'(e));
	endtask

	task wait_sync(input int lim);
		int n;
		c = sc;
		n = 0;
		while (sc == c && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (sc == c) begin
			err_count++;
			finish_test;
		end
	endtask

	// Reset values, node address, heartbeat id, unmapped access
	task t_node;
		chk("hb_id_rst", {21'h0, hbid}, 32'h77F);
		rdchk("cycle_rst", CYCLE_OFS, CYCLE_RST);
		rdchk("mult_rst", MULT_OFS, {24'h0, MULT_RST});
		apb(1'b1, NODE_OFS, 32'h5);
		idle(2);
		chk("hb_id", {21'h0, hbid}, {21'h0, HB_BASE | 11'h005});
		apb(1'b1, NODE_OFS, 32'h0);
		rdchk("hb_reg", HB_ID_OFS, 32'h705);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped_err", {31'h0, err_seen}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
	endtask

	// Host task pacing: multiplier, online reset, edge and source choice, busy bus
	task t_task;
		int n;
		apb(1'b1, MULT_OFS, 32'h2);
		apb(1'b1, CTRL_OFS, 32'h10);
		c = sc;
		repeat (4) begin
			pulse(0);
			idle(20);
		end
		chk("sync_every_2nd", 32'(sc - c), 32'h2);
		ev_sync("first_of_pair", 0, 1);
		apb(1'b1, CTRL_OFS, 32'h30);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			if (crst === 1'b1)
				n++;
		end
		chk("comm_reset_len", 32'(n), 32'(RESET_CYC));
		ev_sync("count_cleared", 0, 1);
		apb(1'b1, MULT_OFS, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h18);
		ev_sync("end_edge_start", 0, 0);
		ev_sync("end_edge_end", 1, 1);
		apb(1'b1, CTRL_OFS, 32'h14);
		ev_sync("hwlink_src", 2, 1);
		ev_sync("hwlink_task", 0, 0);
		apb(1'b1, CTRL_OFS, 32'h00);
		ev_sync("no_sync_pdo", 0, 0);
		apb(1'b1, CTRL_OFS, 32'h10);
		busy <= 1'b1;
		ev_sync("busy_defers", 0, 0);
		busy <= 1'b0;
		wait_sync(20);
	endtask

	// Output PDOs follow SYNC by a percentage of the period
	task t_pdo;
		apb(1'b1, CYCLE_OFS, 32'hC8);
		apb(1'b1, PDO_DLY_OFS, 32'h32);
		c = pc;
		pulse(0);
		idle(150);
		chk("pdo_once", 32'(pc - c), 32'h1);
		chk("pdo_delay", {31'h0, (pa - sa >= 99 && pa - sa <= 102)}, 32'h1);
	endtask

	// Balanced pacing: online reset aligns the local timer, host end arrives on its tick
	task t_bal;
		int n;
		apb(1'b1, CYCLE_OFS, 32'h12C);
		apb(1'b1, TOL_OFS, 32'hFFFF);
		apb(1'b1, SHIFT_OFS, 32'h28);
		apb(1'b1, CTRL_OFS, 32'h32);
		n = 0;
		while (crst !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		chk("bal_reset", {31'h0, crst}, 32'h1);
		// Local tick lands 298 edges after the first high reset sample
		idle(296);
		pulse(1);
		idle(10);
		chk("tx_hold_on", {31'h0, hold}, 32'h1);
		wait_sync(100);
		chk("shift_after_end", {31'h0, (sa - tev >= 40 && sa - tev <= 44)}, 32'h1);
		idle(3);
		chk("tx_hold_off", {31'h0, hold}, 32'h0);
		// Early host end outside a zero tolerance pulls the local period in by one
		apb(1'b1, TOL_OFS, 32'h0);
		pulse(1);
	endtask

	// Master pacing: local SYNC period and host task triggers between SYNCs
	task t_master;
		int s1, tc, n;
		apb(1'b1, CYCLE_OFS, 32'h12C);
		apb(1'b1, MULT_OFS, 32'h2);
		apb(1'b1, SHIFT_OFS, 32'h64);
		apb(1'b1, CTRL_OFS, 32'h11);
		wait_sync(1000);
		s1 = sa;
		c = sc;
		tc = 0;
		n = 0;
		while (sc == c && n < 1000) begin
			@(posedge clk);
			n++;
			if (trig === 1'b1)
				tc++;
		end
		chk("sync_period", 32'(sa - s1), 32'h258);
		chk("task_trigs", 32'(tc), 32'h2);
		apb(1'b1, CTRL_OFS, 32'h00);
	endtask

	// Emergency store read-back and bit rate support check
	task t_diag;
		edata <= 32'hA5A5_0001;
		pulse(3);
		edata <= 32'hA5A5_0002;
		pulse(3);
		rdchk("emcy_cnt", EMCY_CNT_OFS, 32'h2);
		rdchk("emcy_pop", EMCY_POP_OFS, 32'hA5A5_0001);
		rdchk("emcy_left", EMCY_CNT_OFS, 32'h1);
		apb(1'b1, BITRATE_OFS, 32'h3);
		apb(1'b1, SLV_RATE_OFS, 32'h1);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("rate_bad", {31'h0, rd[2]}, 32'h0);
		apb(1'b1, SLV_RATE_OFS, 32'h7);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("rate_ok", {31'h0, rd[2]}, 32'h1);
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		busy = 1'b0;
		evv = 4'h0;
		edata = 32'h0;
		err_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_node;
		t_task;
		t_pdo;
		t_bal;
		t_master;
		t_diag;
		finish_test;
	end
endmodule

// >>> logic/cosync_emcy_store.sv
// Emergency object store read back by the host
`timescale 1ns/10ps
module cosync_emcy_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             clr_i,
	input  wire logic             wr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic             rd_i,
	output logic      [WIDTH-1:0] rdata_o,
	output logic      [7:0]       count_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp, rp, next_wp, next_rp;
	logic [7:0]       cnt, next_cnt;
	logic             do_wr, do_rd;

	// Writes drop when full; the oldest stays readable
	always_comb begin
		do_wr = wr_i && (cnt < 8'(DEPTH));
		do_rd = rd_i && (cnt != 8'h00);
		next_wp = do_wr ? wp + 1'b1 : wp;
		next_rp = do_rd ? rp + 1'b1 : rp;
		next_cnt = cnt + {7'h00, do_wr} - {7'h00, do_rd};
		if (clr_i) begin
			next_wp = '0;
			next_rp = '0;
			next_cnt = 8'h00;
		end
	end

	// Pointer registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= 8'h00;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wp] <= wdata_i;
		end
	end

	assign rdata_o = mem[rp];
	assign count_o = cnt;
endmodule

// >>> logic/cosync_pkg.sv
// Package with register map, field layouts and timing constants of the SYNC scheduler
// Function
// - Own node address 1..127 forms the master heartbeat identifier.
// - With a synchronous PDO configured, SYNC goes out at each cycle start.
// - Slave mode takes its time base from a configured source, host task by default.
// - Host-task source: SYNC on task start or task end, by configuration.
// - Balanced mode holds pending transmits until the cycle's SYNC has gone.
// - Balanced mode spaces SYNC with the local crystal timer.
// - Balanced mode nudges local timer toward host when error exceeds tolerance.
// - Balanced mode issues SYNC a shift delay after the local timer tick that starts the cycle.
// - Master mode: local SYNC, host task start triggered shift delay after reference.
// - SYNC period equals task cycle time times the sync multiplier.
// - Output PDOs wait a percentage of the SYNC period after SYNC.
// - Received emergency objects are stored for later host read-back.
// - Each channel runs on its own resources, never disturbing the other.
// - Host online reset starts a communication reset on the bus.
// - A configured bit rate is checked against each slave's support.
// - A single SYNC may slip one frame on a busy bus; average holds.
// - Only the highest-priority linked task paces the device.
package cosync_pkg;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] NODE_OFS      = 12'h004;
	localparam logic [11:0] CYCLE_OFS     = 12'h008;
	localparam logic [11:0] MULT_OFS      = 12'h00C;
	localparam logic [11:0] SHIFT_OFS     = 12'h010;
	localparam logic [11:0] TOL_OFS       = 12'h014;
	localparam logic [11:0] PDO_DLY_OFS   = 12'h018;
	localparam logic [11:0] STATUS_OFS    = 12'h01C;
	localparam logic [11:0] BITRATE_OFS   = 12'h020;
	localparam logic [11:0] SLV_RATE_OFS  = 12'h024;
	localparam logic [11:0] EMCY_CNT_OFS  = 12'h028;
	localparam logic [11:0] EMCY_POP_OFS  = 12'h02C;
	localparam logic [11:0] HB_ID_OFS     = 12'h030;
	// Control fields
	localparam int CTRL_MODE_BIT   = 0; // 0 slave, 1 master
	localparam int CTRL_SRC_LO     = 1; // 2-bit sync source
	localparam int CTRL_EDGE_BIT   = 3; // 0 task start, 1 task end
	localparam int CTRL_SYNCPDO    = 4; // a synchronous PDO is configured
	localparam int CTRL_ORST_BIT   = 5; // online reset request, self clearing
	// Reset values
	localparam logic [6:0]  NODE_RST   = 7'h7F;
	localparam logic [31:0] CYCLE_RST  = 32'h0000_C350; // 1 ms at 50 MHz
	localparam logic [7:0]  MULT_RST   = 8'h01;
	localparam logic [31:0] SHIFT_RST  = 32'h0000_0000;
	localparam logic [15:0] TOL_RST    = 16'h0000;
	localparam logic [6:0]  PDO_RST    = 7'h00;
	localparam logic [5:0]  CTRL_RST   = 6'h00;
	// Heartbeat function code base
	localparam logic [10:0] HB_BASE    = 11'h700;
	localparam logic [6:0]  NODE_MIN   = 7'h01;
	// Timing: one frame at the slowest rate and the nudge step
	localparam int CLK_MHZ        = 50;
	localparam int FRAME_US       = 135;
	localparam int FRAME_CYC      = FRAME_US * CLK_MHZ;
	localparam logic [31:0] NUDGE = 32'h0000_0001;
	localparam int RESET_CYC      = 16;
	// Timing modes and sync sources
	typedef enum logic [1:0] {SRC_TASK, SRC_BALANCED, SRC_HWLINK} cosync_src_e;
endpackage

// >>> logic/cosync_sched.sv
// SYNC scheduler top: APB registers, SYNC timing, PDO delay and host task pacing
`timescale 1ns/10ps
module cosync_sched
	import cosync_pkg::*;
#(
	parameter int EMCY_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Host task events
	input  wire logic        TASK_START_I,
	input  wire logic        TASK_END_I,
	input  wire logic        HWLINK_I,
	output logic             TASK_TRIG_O,
	// CAN controller side
	input  wire logic        BUS_BUSY_I,
	input  wire logic        TX_PENDING_I,
	input  wire logic        EMCY_VALID_I,
	input  wire logic [31:0] EMCY_DATA_I,
	output logic             SYNC_REQ_O,
	output logic             PDO_REQ_O,
	output logic             TX_HOLD_O,
	output logic             COMM_RESET_O,
	output logic [10:0]      HB_ID_O
);
	// Channel independence: each channel instantiates its own copy.
	// Pacing events come only from the highest-priority task port.

	logic [5:0]  ctrl, next_ctrl;
	logic [6:0]  node, next_node;
	logic [31:0] cycle, next_cycle;
	logic [7:0]  mult, next_mult;
	logic [31:0] shift, next_shift;
	logic [15:0] tol, next_tol;
	logic [6:0]  pdo_pct, next_pdo_pct;
	logic [31:0] bitrate, next_bitrate;
	logic [31:0] slv_rate, next_slv_rate;
	logic [31:0] prdata, next_prdata;
	logic        pready, next_pready;
	logic        pslverr, next_pslverr;
	logic        online_rst;
	logic        acc, wr, rd, emcy_pop;
	logic [31:0] emcy_rdata;
	logic [7:0]  emcy_cnt;
	logic        rate_ok;

	assign acc = PSEL_I && PENABLE_I && !pready;
	assign wr = acc && PWRITE_I;
	assign rd = acc && !PWRITE_I;
	assign emcy_pop = rd && (PADDR_I == EMCY_POP_OFS);
	assign online_rst = ctrl[CTRL_ORST_BIT];
	assign rate_ok = (slv_rate & bitrate) == bitrate;

	// Register writes and APB answer, one wait state
	always_comb begin
		next_ctrl = ctrl & ~(6'h01 << CTRL_ORST_BIT);
		next_node = node;
		next_cycle = cycle;
		next_mult = mult;
		next_shift = shift;
		next_tol = tol;
		next_pdo_pct = pdo_pct;
		next_bitrate = bitrate;
		next_slv_rate = slv_rate;
		next_prdata = prdata;
		next_pready = acc;
		next_pslverr = 1'b0;
		if (wr) begin
			case (PADDR_I)
				CTRL_OFS:     next_ctrl = PWDATA_I[5:0];
				NODE_OFS: begin
					if (PWDATA_I[6:0] >= NODE_MIN) begin
						next_node = PWDATA_I[6:0];
					end
				end
				CYCLE_OFS:    next_cycle = PWDATA_I;
				MULT_OFS:     next_mult = (PWDATA_I[7:0] == 8'h00) ? MULT_RST : PWDATA_I[7:0];
				SHIFT_OFS:    next_shift = PWDATA_I;
				TOL_OFS:      next_tol = PWDATA_I[15:0];
				PDO_DLY_OFS:  next_pdo_pct = (PWDATA_I[6:0] > 7'h64) ? 7'h64 : PWDATA_I[6:0];
				BITRATE_OFS:  next_bitrate = PWDATA_I;
				SLV_RATE_OFS: next_slv_rate = PWDATA_I;
				default:      next_pslverr = 1'b1;
			endcase
		end else if (rd) begin
			case (PADDR_I)
				CTRL_OFS:     next_prdata = {26'h0, ctrl};
				NODE_OFS:     next_prdata = {25'h0, node};
				CYCLE_OFS:    next_prdata = cycle;
				MULT_OFS:     next_prdata = {24'h0, mult};
				SHIFT_OFS:    next_prdata = shift;
				TOL_OFS:      next_prdata = {16'h0, tol};
				PDO_DLY_OFS:  next_prdata = {25'h0, pdo_pct};
				STATUS_OFS:   next_prdata = {29'h0, rate_ok, TX_HOLD_O, COMM_RESET_O};
				BITRATE_OFS:  next_prdata = bitrate;
				SLV_RATE_OFS: next_prdata = slv_rate;
				EMCY_CNT_OFS: next_prdata = {24'h0, emcy_cnt};
				EMCY_POP_OFS: next_prdata = emcy_rdata;
				HB_ID_OFS:    next_prdata = {21'h0, HB_ID_O};
				default: begin
					next_prdata = 32'h0000_0000;
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	// Register file flip-flops
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			ctrl <= CTRL_RST;
			node <= NODE_RST;
			cycle <= CYCLE_RST;
			mult <= MULT_RST;
			shift <= SHIFT_RST;
			tol <= TOL_RST;
			pdo_pct <= PDO_RST;
			bitrate <= 32'h0000_0000;
			slv_rate <= 32'h0000_0000;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			node <= next_node;
			cycle <= next_cycle;
			mult <= next_mult;
			shift <= next_shift;
			tol <= next_tol;
			pdo_pct <= next_pdo_pct;
			bitrate <= next_bitrate;
			slv_rate <= next_slv_rate;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign PRDATA_O = prdata;
	assign PREADY_O = pready;
	assign PSLVERR_O = pslverr;

	// Emergency store, flushed by online reset
	cosync_emcy_store #(
		.WIDTH (32),
		.DEPTH (EMCY_DEPTH)
	) u_emcy (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.clr_i   (online_rst),
		.wr_i    (EMCY_VALID_I),
		.wdata_i (EMCY_DATA_I),
		.rd_i    (emcy_pop),
		.rdata_o (emcy_rdata),
		.count_o (emcy_cnt)
	);

	// Timing core state
	logic        mode_master, edge_end, syncpdo;
	cosync_src_e src;
	logic        host_evt, tick_local;
	logic [31:0] loc_cnt, next_loc_cnt, loc_per, next_loc_per, host_cnt, next_host_cnt;
	logic [7:0]  cyc_cnt, next_cyc_cnt;
	logic [31:0] shift_cnt, next_shift_cnt;
	logic        shift_run, next_shift_run;
	logic        sync_due, next_sync_due;
	logic [31:0] slip, next_slip;
	logic [31:0] pdo_cnt, next_pdo_cnt;
	logic        pdo_run, next_pdo_run;
	logic [39:0] pdo_target;
	logic [4:0]  rst_cnt, next_rst_cnt;
	logic        sync_req, next_sync_req, pdo_req, next_pdo_req, hold, next_hold;
	logic        trig, next_trig, comm_rst, next_comm_rst;
	logic [31:0] sync_per;

	assign mode_master = ctrl[CTRL_MODE_BIT];
	assign src = cosync_src_e'(ctrl[CTRL_SRC_LO+:2]);
	assign edge_end = ctrl[CTRL_EDGE_BIT];
	assign syncpdo = ctrl[CTRL_SYNCPDO];
	assign host_evt = (src == SRC_HWLINK) ? HWLINK_I :
		(edge_end ? TASK_END_I : TASK_START_I);
	assign tick_local = (loc_cnt >= loc_per - 32'h1);
	assign sync_per = 32'(cycle * mult);
	assign pdo_target = 40'((64'(sync_per) * pdo_pct) / 100);

	// Timing core next state
	always_comb begin
		next_loc_cnt = tick_local ? 32'h0 : loc_cnt + 32'h1;
		next_loc_per = loc_per;
		next_host_cnt = host_cnt + 32'h1;
		next_cyc_cnt = cyc_cnt;
		next_shift_cnt = shift_cnt;
		next_shift_run = shift_run;
		next_sync_due = sync_due;
		next_slip = slip;
		next_pdo_cnt = pdo_cnt;
		next_pdo_run = pdo_run;
		next_sync_req = 1'b0;
		next_pdo_req = 1'b0;
		next_trig = 1'b0;
		next_hold = hold;
		next_rst_cnt = (rst_cnt != 5'h0) ? rst_cnt - 5'h1 : 5'h0;
		next_comm_rst = (rst_cnt != 5'h0);
		if (mode_master || src == SRC_BALANCED) begin
			// Local crystal cycle per task cycle
			if (tick_local) begin
				next_cyc_cnt = (cyc_cnt + 8'h1 >= mult) ? 8'h0 : cyc_cnt + 8'h1;
				next_shift_run = 1'b1;
				next_shift_cnt = 32'h0;
				// Hold from cycle start, so task outputs cannot overtake this SYNC
				if (!mode_master && syncpdo && next_cyc_cnt == 8'h0) begin
					next_hold = 1'b1;
				end
			end
			// Host end compared with local timebase; nudge when outside tolerance
			if (!mode_master && TASK_END_I) begin
				next_host_cnt = 32'h0;
				if (host_cnt > loc_per + {16'h0, tol}) begin
					next_loc_per = loc_per + NUDGE;
				end else if (host_cnt + {16'h0, tol} < loc_per) begin
					next_loc_per = loc_per - NUDGE;
				end
			end
			if (shift_run) begin
				next_shift_cnt = shift_cnt + 32'h1;
				if (shift_cnt >= shift) begin
					next_shift_run = 1'b0;
					if (mode_master) begin
						next_trig = 1'b1;
					end
					if (cyc_cnt == 8'h0 && syncpdo) begin
						next_sync_due = 1'b1;
						next_hold = !mode_master;
					end
				end
			end
		end else if (host_evt) begin
			next_cyc_cnt = (cyc_cnt + 8'h1 >= mult) ? 8'h0 : cyc_cnt + 8'h1;
			if (cyc_cnt == 8'h0 && syncpdo) begin
				next_sync_due = 1'b1;
			end
		end
		// Busy bus defers SYNC, bounded by one frame
		if (sync_due) begin
			next_slip = slip + 32'h1;
			if (!BUS_BUSY_I || slip >= 32'(FRAME_CYC)) begin
				next_sync_req = 1'b1;
				next_sync_due = 1'b0;
				next_slip = 32'h0;
				next_hold = 1'b0;
				next_pdo_run = 1'b1;
				next_pdo_cnt = 32'h0;
			end
		end
		if (pdo_run) begin
			next_pdo_cnt = pdo_cnt + 32'h1;
			if (40'(pdo_cnt) >= pdo_target) begin
				next_pdo_run = 1'b0;
				next_pdo_req = 1'b1;
			end
		end
		// New multiplier restarts the count so it never sits past the limit
		if (wr && PADDR_I == MULT_OFS) begin
			next_cyc_cnt = 8'h0;
		end
		// New cycle time retunes the local period at once
		if (wr && PADDR_I == CYCLE_OFS) begin
			next_loc_per = PWDATA_I;
		end
		if (online_rst) begin
			next_rst_cnt = 5'(RESET_CYC);
			next_cyc_cnt = 8'h0;
			next_shift_run = 1'b0;
			next_sync_due = 1'b0;
			next_pdo_run = 1'b0;
			next_hold = 1'b0;
			next_loc_cnt = 32'h0;
			next_loc_per = cycle;
		end
	end

	// Timing core flip-flops
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			loc_cnt <= 32'h0;
			loc_per <= CYCLE_RST;
			host_cnt <= 32'h0;
			cyc_cnt <= 8'h0;
			shift_cnt <= 32'h0;
			shift_run <= 1'b0;
			sync_due <= 1'b0;
			slip <= 32'h0;
			pdo_cnt <= 32'h0;
			pdo_run <= 1'b0;
			rst_cnt <= 5'h0;
			sync_req <= 1'b0;
			pdo_req <= 1'b0;
			hold <= 1'b0;
			trig <= 1'b0;
			comm_rst <= 1'b0;
		end else begin
			loc_cnt <= next_loc_cnt;
			loc_per <= next_loc_per;
			host_cnt <= next_host_cnt;
			cyc_cnt <= next_cyc_cnt;
			shift_cnt <= next_shift_cnt;
			shift_run <= next_shift_run;
			sync_due <= next_sync_due;
			slip <= next_slip;
			pdo_cnt <= next_pdo_cnt;
			pdo_run <= next_pdo_run;
			rst_cnt <= next_rst_cnt;
			sync_req <= next_sync_req;
			pdo_req <= next_pdo_req;
			hold <= next_hold;
			trig <= next_trig;
			comm_rst <= next_comm_rst;
		end
	end

	assign SYNC_REQ_O = sync_req;
	assign PDO_REQ_O = pdo_req;
	assign TX_HOLD_O = hold && TX_PENDING_I ? 1'b1 : hold;
	assign TASK_TRIG_O = trig;
	assign COMM_RESET_O = comm_rst;
	assign HB_ID_O = HB_BASE | {4'h0, node};

	// Checks
	sequence s_sync_out;
		sync_req ##1 !sync_req;
	endsequence

	node_range_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) node >= NODE_MIN)
		else $error("node address left range");
	hb_ident_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		HB_ID_O[6:0] == node && HB_ID_O[10:7] == 4'hE)
		else $error("heartbeat id mismatch");
	sync_needs_pdo_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		$rose(sync_req) |-> $past(syncpdo, 2))
		else $error("sync without sync pdo");
	sync_pulse_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		sync_req |-> s_sync_out)
		else $error("sync pulse too long");
	hold_release_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		sync_req |-> !hold)
		else $error("transmit hold not released at sync");
	reset_pulse_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		online_rst |=> ##1 comm_rst)
		else $error("online reset not forwarded");
	reset_clear_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		online_rst |=> cyc_cnt == 8'h0 && !sync_due && !pdo_run)
		else $error("online reset did not clear timing");
	pdo_after_sync_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		pdo_req |-> !sync_req)
		else $error("pdo request with sync");
	trig_master_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		trig |-> $past(mode_master))
		else $error("task trigger outside master mode");
	cyc_bound_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) cyc_cnt < mult)
		else $error("cycle counter past multiplier");
	nudge_step_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		$changed(loc_per) && !$past(online_rst) && !$past(wr && PADDR_I == CYCLE_OFS)
		|-> loc_per == $past(loc_per) + NUDGE || loc_per == $past(loc_per) - NUDGE)
		else $error("local period stepped too far");
endmodule
